//--- hw/lfs_pkg.sv
package lfs_pkg;
   // timebase
   localparam int CLK_KHZ = 10_000;
   localparam int US_PER_MS = 1000;
   localparam int AUX_TIMEOUT_MS = 90;
   localparam int RECOVER_MS = 4000;
   localparam int FOLD_STEP_US = 100;
   localparam int AUX_CYCLES = AUX_TIMEOUT_MS * CLK_KHZ;
   localparam int RECOVER_CYCLES = RECOVER_MS * CLK_KHZ;
   localparam int FOLD_STEP_CYCLES = FOLD_STEP_US * CLK_KHZ / US_PER_MS;
   // protection counts
   localparam int WSC_TRIP_COUNT = 4;
   localparam logic [2:0] WSC_TRIP = 3'h4;
   // reference codes, one lsb per mV
   localparam logic [7:0] REF_NOMINAL = 8'hFA;
   localparam logic [7:0] REF_FLOOR = 8'h7D;
   localparam logic [7:0] REF_STEP = 8'h01;
   localparam logic [7:0] SP_DELTA = 8'h10;
   // valley choice
   localparam logic [2:0] VALLEY_LOW_LINE = 3'h1;
   localparam logic [2:0] VALLEY_HIGH_LINE = 3'h2;
   localparam logic [2:0] VALLEY_LIGHT_EXTRA = 3'h2;
   localparam logic [2:0] VALLEY_ONE = 3'h1;
   // synchronised pin positions
   localparam int P_CS_LIMIT = 0;
   localparam int P_CS_WSC = 1;
   localparam int P_CS_SETPT = 2;
   localparam int P_CS_BAD = 3;
   localparam int P_VALLEY = 4;
   localparam int P_ZCD_OK = 5;
   localparam int P_VCC_OVP = 6;
   localparam int P_SD_FOLD = 7;
   localparam int P_SD_STOP = 8;
   localparam int P_SD_SHUT = 9;
   localparam int P_OVERHEAT = 10;
   localparam int P_BROWN = 11;
   localparam int P_GND_FLOAT = 12;
   localparam int P_SUPPLY = 13;
   localparam int P_OTA_SINK = 14;
   localparam int P_DIM_FULL = 15;
   localparam int P_LINE_HIGH = 16;
   localparam int P_LIGHT = 17;
   localparam int P_LATCH = 18;
   localparam int P_LINE_ZERO = 19;
   localparam int NPINS = 20;

   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_RUN = 4'h2,
      ST_WAIT = 4'h4,
      ST_LATCH = 4'h8
   } lfs_state_e;
endpackage : lfs_pkg

//--- hw/lfs_sync.sv
`timescale 1ns/1ps
module lfs_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lfs_sync_s;

   lfs_sync_s q;
   lfs_sync_s d;

   // first stage feeds only the second
   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;
endmodule : lfs_sync

//--- hw/lfs_fault_seq.sv
`timescale 1ns/1ps
module lfs_fault_seq
   import lfs_pkg::*;
#(
   parameter int AUX_CYC = AUX_CYCLES,
   parameter int RECOVER_CYC = RECOVER_CYCLES,
   parameter int FOLD_CYC = FOLD_STEP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_over_limit,
   input wire logic cs_over_wsc,
   input wire logic cs_over_setpoint,
   input wire logic cs_pin_fault,
   input wire logic valley_sense_input,
   input wire logic valley_sense_above_short,
   input wire logic vcc_overvoltage,
   input wire logic thermal_shutdown_input,
   input wire logic thermal_stop_level,
   input wire logic shutdown_pin_fault,
   input wire logic die_overheat_fault,
   input wire logic brown_out,
   input wire logic gnd_floating,
   input wire logic supply_above_start,
   input wire logic ota_sinking,
   input wire logic dim_input,
   input wire logic line_high,
   input wire logic light_load,
   input wire logic latch_variant,
   input wire logic line_zero,
   input wire logic [7:0] dim_level,
   input wire logic [7:0] comp_code,
   output logic gate_drive,
   output logic comp_ground,
   output logic comp_boost,
   output logic [7:0] current_reference,
   output logic [7:0] current_setpoint,
   output logic [2:0] valley_select,
   output logic aux_short_fault,
   output logic recovery_wait,
   output logic fault_latched
);
   localparam int AUX_W = $clog2(AUX_CYC + 1);
   localparam int WAIT_W = $clog2(RECOVER_CYC + 1);
   localparam int FOLD_W = $clog2(FOLD_CYC + 1);
   localparam logic [AUX_W-1:0] AUX_LAST = AUX_W'(AUX_CYC - 1);
   localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(RECOVER_CYC - 1);
   localparam logic [FOLD_W-1:0] FOLD_LAST = FOLD_W'(FOLD_CYC - 1);

   typedef struct packed {
      lfs_state_e st;
      logic strap_done;
      logic latch_mode;
      logic vp_prev;
      logic lz_prev;
      logic [AUX_W-1:0] aux_cnt;
      logic [WAIT_W-1:0] wait_cnt;
      logic [FOLD_W-1:0] fold_tick;
      logic [2:0] wsc_cnt;
      logic wsc_seen;
      logic [7:0] fold_ref;
      logic [7:0] cur_ref;
      logic [7:0] setpoint;
      logic [7:0] lock_sp;
      logic lock_line;
      logic lock_light;
      logic [2:0] valley;
      logic [2:0] valley_cnt;
      logic drv;
      logic comp_gnd;
      logic boost;
      logic aux_fault;
      logic latched;
      logic in_wait;
   } lfs_core_s;

   logic [NPINS-1:0] pin_raw;
   logic [NPINS-1:0] pin;
   lfs_core_s q;
   lfs_core_s d;

   assign pin_raw = {line_zero, latch_variant, light_load, line_high, dim_input,
                     ota_sinking, supply_above_start, gnd_floating, brown_out,
                     die_overheat_fault, shutdown_pin_fault, thermal_stop_level,
                     thermal_shutdown_input, vcc_overvoltage, valley_sense_above_short,
                     valley_sense_input, cs_pin_fault, cs_over_setpoint, cs_over_wsc,
                     cs_over_limit};

   lfs_sync #(.W(NPINS)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(pin_raw),
      .sync_out(pin)
   );

   logic vp_rise;
   logic lz_rise;
   logic halt;
   logic gnd_req;
   logic cycle_end;
   logic relock;
   logic [15:0] dim_prod;
   logic [7:0] sp_diff;
   logic [2:0] valley_next;
   logic [2:0] valley_base;

   always_comb begin
      d = q;
      vp_rise = pin[P_VALLEY] & ~q.vp_prev;
      lz_rise = pin[P_LINE_ZERO] & ~q.lz_prev;
      d.vp_prev = pin[P_VALLEY];
      d.lz_prev = pin[P_LINE_ZERO];

      // variant strap followed until the first start from off
      // the sync flops read zero just after reset, so an early grab is wrong
      if (!q.strap_done) begin
         d.latch_mode = pin[P_LATCH];
         d.strap_done = (q.st != ST_OFF) ? 1'b1 : 1'b0;
      end

      // slow ramp so the loop is not kicked by a step in reference
      if (q.fold_tick == FOLD_LAST) begin
         d.fold_tick = '0;
         if (pin[P_SD_FOLD] && q.fold_ref > REF_FLOOR) begin
            d.fold_ref = q.fold_ref - REF_STEP;
         end else if (!pin[P_SD_FOLD] && q.fold_ref < REF_NOMINAL) begin
            d.fold_ref = q.fold_ref + REF_STEP;
         end
      end else begin
         d.fold_tick = q.fold_tick + FOLD_W'(1);
      end

      dim_prod = q.fold_ref * dim_level;
      // reset value held until strap_done is set by the first start from off
      if (q.strap_done) begin
         d.cur_ref = pin[P_DIM_FULL] ? q.fold_ref : dim_prod[15:8];
      end

      // one sample per half-line cycle drops the ripple
      if (lz_rise) begin
         d.setpoint = comp_code;
      end

      // hysteresis on the setpoint keeps the valley from hunting
      sp_diff = (q.setpoint > q.lock_sp) ? q.setpoint - q.lock_sp : q.lock_sp - q.setpoint;
      relock = (sp_diff > SP_DELTA) || (pin[P_LINE_HIGH] != q.lock_line)
               || (pin[P_LIGHT] != q.lock_light);
      valley_base = pin[P_LINE_HIGH] ? VALLEY_HIGH_LINE : VALLEY_LOW_LINE;
      valley_next = pin[P_LIGHT] ? valley_base + VALLEY_LIGHT_EXTRA : valley_base;
      if (relock) begin
         d.lock_sp = q.setpoint;
         d.lock_line = pin[P_LINE_HIGH];
         d.lock_light = pin[P_LIGHT];
         d.valley = valley_next;
      end

      // these hold the gate low only while present, no recovery wait
      halt = pin[P_CS_BAD] | pin[P_SD_STOP] | pin[P_OVERHEAT] | pin[P_BROWN]
             | pin[P_GND_FLOAT];
      gnd_req = pin[P_OVERHEAT] | pin[P_BROWN] | pin[P_GND_FLOAT];
      cycle_end = 1'b0;

      unique case (q.st)
         ST_OFF: begin
            d.drv = 1'b0;
            d.comp_gnd = 1'b1;
            d.boost = 1'b0;
            // values held across the retry, only rst_n clears them
            if (pin[P_SUPPLY] && !pin[P_BROWN] && !pin[P_GND_FLOAT]) begin
               d.st = ST_RUN;
               d.comp_gnd = 1'b0;
               d.boost = 1'b1;
            end
         end
         ST_RUN: begin
            d.comp_gnd = gnd_req;
            if (pin[P_OTA_SINK]) begin
               d.boost = 1'b0;
            end
            if (pin[P_ZCD_OK]) begin
               d.aux_cnt = '0;
            end else begin
               d.aux_cnt = q.aux_cnt + AUX_W'(1);
            end
            if (q.drv && pin[P_CS_WSC]) begin
               d.wsc_seen = 1'b1;
            end
            // valley edges during the on-time are ignored
            if (q.drv) begin
               // pin sync makes this cut two to three cycles late
               if (pin[P_CS_LIMIT] || pin[P_CS_SETPT] || halt) begin
                  d.drv = 1'b0;
                  cycle_end = 1'b1;
               end
            end else if (!halt && vp_rise) begin
               if (q.valley_cnt + VALLEY_ONE >= q.valley) begin
                  d.drv = 1'b1;
                  d.valley_cnt = '0;
               end else begin
                  d.valley_cnt = q.valley_cnt + VALLEY_ONE;
               end
            end
            if (cycle_end) begin
               d.wsc_seen = 1'b0;
               if (q.wsc_seen || pin[P_CS_WSC]) begin
                  d.wsc_cnt = (q.wsc_cnt == WSC_TRIP) ? q.wsc_cnt : q.wsc_cnt + 3'h1;
               end else begin
                  d.wsc_cnt = '0;
               end
            end
            if (pin[P_SD_SHUT] || q.wsc_cnt == WSC_TRIP) begin
               d.st = q.latch_mode ? ST_LATCH : ST_WAIT;
               d.latched = q.latch_mode;
            end else if (q.aux_cnt == AUX_LAST && !pin[P_ZCD_OK]) begin
               d.st = ST_WAIT;
               d.aux_fault = 1'b1;
            end else if (pin[P_VCC_OVP]) begin
               d.st = ST_WAIT;
            end else if (!pin[P_SUPPLY]) begin
               d.st = ST_OFF;
            end
            if (d.st != ST_RUN) begin
               d.drv = 1'b0;
               d.comp_gnd = 1'b1;
               d.boost = 1'b0;
               d.wait_cnt = '0;
               d.wsc_cnt = '0;
               d.wsc_seen = 1'b0;
               // a fresh aux interval begins on every return to run
               d.aux_cnt = '0;
               d.valley_cnt = '0;
            end
         end
         ST_WAIT: begin
            d.drv = 1'b0;
            d.comp_gnd = 1'b1;
            if (q.wait_cnt == WAIT_LAST) begin
               d.st = ST_OFF;
               d.aux_fault = 1'b0;
               d.wait_cnt = '0;
            end else begin
               d.wait_cnt = q.wait_cnt + WAIT_W'(1);
            end
         end
         ST_LATCH: begin
            // only rst_n leaves this state
            d.drv = 1'b0;
            d.comp_gnd = 1'b1;
         end
         default: begin
            d.st = ST_OFF;
            d.drv = 1'b0;
            d.comp_gnd = 1'b1;
         end
      endcase
      // registered so the wait flag leaves a flop like the other outputs
      d.in_wait = (d.st == ST_WAIT) ? 1'b1 : 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= ST_OFF;
         q.comp_gnd <= 1'b1;
         q.fold_ref <= REF_NOMINAL;
         q.cur_ref <= REF_NOMINAL;
         q.valley <= VALLEY_LOW_LINE;
      end else begin
         q <= d;
      end
   end

   assign gate_drive = q.drv;
   assign comp_ground = q.comp_gnd;
   assign comp_boost = q.boost;
   assign current_reference = q.cur_ref;
   assign current_setpoint = q.setpoint;
   assign valley_select = q.valley;
   assign aux_short_fault = q.aux_fault;
   assign recovery_wait = q.in_wait;
   assign fault_latched = q.latched;
endmodule : lfs_fault_seq

//--- sim/lfs_fault_seq_asserts.sv
`timescale 1ns/1ps
module lfs_fault_seq_asserts
   import lfs_pkg::*;
#(
   parameter int AUX_CYC = AUX_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_over_limit,
   input wire logic cs_over_setpoint,
   input wire logic cs_pin_fault,
   input wire logic valley_sense_above_short,
   input wire logic thermal_stop_level,
   input wire logic die_overheat_fault,
   input wire logic brown_out,
   input wire logic gnd_floating,
   input wire logic ota_sinking,
   input wire logic gate_drive,
   input wire logic comp_ground,
   input wire logic comp_boost,
   input wire logic aux_short_fault,
   input wire logic recovery_wait,
   input wire logic fault_latched
);
   // raw quiet time, shorter than what the synced logic saw only in the two cycles after a raw rise
   logic [31:0] quiet_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_q <= '0;
      end else begin
         quiet_q <= valley_sense_above_short ? '0 : quiet_q + 32'h0000_0001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // four samples cover the two sync flops plus the state flop
   sequence s_held4(x);
      x[*4];
   endsequence
   property p_peak; gate_drive && cs_over_limit |-> ##[1:3] !gate_drive; endproperty
   a_peak: assert property (p_peak) else $error("peak cut late");
   property p_setpt; gate_drive && cs_over_setpoint |-> ##[1:3] !gate_drive; endproperty
   a_setpt: assert property (p_setpt) else $error("setpoint cut late");
   property p_cspin; s_held4(cs_pin_fault) |=> !gate_drive; endproperty
   a_cspin: assert property (p_cspin) else $error("cs pin fault ignored");
   property p_tstop; s_held4(thermal_stop_level) |=> !gate_drive; endproperty
   a_tstop: assert property (p_tstop) else $error("thermal stop ignored");
   property p_gnd;
      s_held4(brown_out || gnd_floating || die_overheat_fault) |=> comp_ground;
   endproperty
   a_gnd: assert property (p_gnd) else $error("comp not grounded");
   property p_wait; recovery_wait || fault_latched |-> comp_ground && !gate_drive; endproperty
   a_wait: assert property (p_wait) else $error("fault state still active");
   property p_boost; s_held4(ota_sinking) |=> !comp_boost; endproperty
   a_boost: assert property (p_boost) else $error("boost kept on");
   property p_aux; $rose(aux_short_fault) |-> quiet_q >= AUX_CYC; endproperty
   a_aux: assert property (p_aux) else $error("aux short too early");
endmodule : lfs_fault_seq_asserts
bind lfs_fault_seq lfs_fault_seq_asserts #(.AUX_CYC(AUX_CYC)) u_chk (.sys_clk, .rst_n,
   .cs_over_limit, .cs_over_setpoint, .cs_pin_fault, .valley_sense_above_short,
   .thermal_stop_level, .die_overheat_fault, .brown_out, .gnd_floating, .ota_sinking,
   .gate_drive, .comp_ground, .comp_boost, .aux_short_fault, .recovery_wait, .fault_latched);

//--- sim/lfs_stage.sv
`timescale 1ns/1ps
module lfs_stage (
   input wire logic sys_clk,
   input wire logic gate_drive,
   input wire logic slow,
   input wire logic aux_ok,
   input wire logic wsc_en,
   output logic valley_sense_input,
   output logic valley_sense_above_short,
   output logic cs_over_setpoint,
   output logic cs_over_wsc
);
   int on_q = 0;
   initial {valley_sense_input, valley_sense_above_short, cs_over_setpoint, cs_over_wsc} = '0;
   always @(posedge sys_clk) begin
      #1;
      // ramp length stands in for the inductor current rise
      on_q = gate_drive ? on_q + 1 : 0;
      cs_over_setpoint = on_q > (slow ? 20 : 2);
      cs_over_wsc = wsc_en && gate_drive;
      // ringing only while the switch is open
      valley_sense_input = !gate_drive && !valley_sense_input;
      valley_sense_above_short = aux_ok && valley_sense_input;
   end
endmodule : lfs_stage

//--- sim/lfs_fault_seq_tb.sv
`timescale 1ns/1ps
module lfs_fault_seq_tb
   import lfs_pkg::*;
;
   localparam int AUXC = 200;
   localparam int RECC = 300;
   typedef struct {int s; logic [7:0] v;} lfs_note_s;
   logic sys_clk = 0;
   logic rst_n = 0;
   logic cs_over_limit, vcc_overvoltage, thermal_shutdown_input, shutdown_pin_fault;
   logic supply_above_start, ota_sinking, dim_input, line_high, light_load, latch_variant;
   logic line_zero, slow, aux_ok, wsc_en;
   logic [4:0] halt;
   logic [7:0] dim_level, comp_code, current_reference, current_setpoint;
   logic valley_sense_input, valley_sense_above_short, cs_over_setpoint, cs_over_wsc;
   logic gate_drive, comp_ground, comp_boost, aux_short_fault, recovery_wait, fault_latched;
   logic [2:0] valley_select;
   lfs_note_s q[$];
   lfs_note_s nt;
   int n_mismatch = 0;
   int n_checks = 0;
   int seed = 8434;
   wire [71:0] ov = {current_setpoint, 7'h00, fault_latched, 7'h00, recovery_wait, 7'h00,
      aux_short_fault, 5'h00, valley_select, current_reference, 7'h00, comp_boost, 7'h00,
      comp_ground, 7'h00, gate_drive};
   always #50 sys_clk = ~sys_clk;
   lfs_stage u_stage (.sys_clk, .gate_drive, .slow, .aux_ok, .wsc_en, .valley_sense_input,
      .valley_sense_above_short, .cs_over_setpoint, .cs_over_wsc);
   lfs_fault_seq #(.AUX_CYC(AUXC), .RECOVER_CYC(RECC), .FOLD_CYC(4)) uut (.sys_clk, .rst_n,
      .cs_over_limit, .cs_over_wsc, .cs_over_setpoint, .cs_pin_fault(halt[0]),
      .valley_sense_input, .valley_sense_above_short, .vcc_overvoltage,
      .thermal_shutdown_input, .thermal_stop_level(halt[1]), .shutdown_pin_fault,
      .die_overheat_fault(halt[2]), .brown_out(halt[3]), .gnd_floating(halt[4]),
      .supply_above_start, .ota_sinking, .dim_input, .line_high, .light_load, .latch_variant,
      .line_zero, .dim_level, .comp_code, .gate_drive, .comp_ground, .comp_boost,
      .current_reference, .current_setpoint, .valley_select, .aux_short_fault,
      .recovery_wait, .fault_latched);
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic ex(int s, logic [7:0] v);
      q.push_back('{s, v});
   endtask : ex
   task automatic chk(logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   always @(negedge sys_clk) begin
      while (q.size() > 0) begin
         nt = q.pop_front();
         chk(nt.v, ov[nt.s*8 +: 8]);
      end
   end
   task automatic wait_gate(logic v);
      int k;
      k = 0;
      while (gate_drive !== v && k < 400) begin
         cyc(1);
         k++;
      end
      if (k == 400) begin
         n_mismatch++;
         $display("[ERR] %0t gate stuck", $time);
      end
   endtask : wait_gate
   task automatic pulses(int n);
      repeat (n) begin
         wait_gate(1);
         wait_gate(0);
      end
   endtask : pulses
   task automatic do_reset(logic lv);
      rst_n = 0;
      {cs_over_limit, vcc_overvoltage, thermal_shutdown_input, shutdown_pin_fault} = '0;
      {supply_above_start, ota_sinking, line_high, light_load, line_zero, slow, wsc_en} = '0;
      {halt, dim_level, comp_code} = '0;
      {dim_input, aux_ok, latch_variant} = {2'b11, lv};
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1;
   endtask : do_reset
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   initial begin
      do_reset(0);
      ex(1, 8'h01);
      ex(3, REF_NOMINAL);
      supply_above_start = 1;
      cyc(4);
      ex(1, 8'h00);
      ex(2, 8'h01);
      ota_sinking = 1;
      cyc(4);
      ex(2, 8'h00);
      ota_sinking = 0;
      $display("start done");
      slow = 1;
      wait_gate(1);
      cs_over_limit = 1;
      cyc(3);
      ex(0, 8'h00);
      cs_over_limit = 0;
      wait_gate(1);
      cyc(6);
      ex(0, 8'h01);
      slow = 0;
      wait_gate(0);
      wsc_en = 1;
      pulses(3);
      wsc_en = 0;
      pulses(1);
      wsc_en = 1;
      pulses(3);
      cyc(3);
      ex(6, 8'h00);
      pulses(1);
      wsc_en = 0;
      cyc(3);
      ex(6, 8'h01);
      cyc(RECC + 10);
      ex(6, 8'h00);
      $display("winding done");
      aux_ok = 0;
      cyc(AUXC - 50);
      aux_ok = 1;
      cyc(20);
      aux_ok = 0;
      cyc(AUXC - 50);
      ex(5, 8'h00);
      cyc(70);
      ex(5, 8'h01);
      aux_ok = 1;
      cyc(RECC + 20);
      ex(5, 8'h00);
      vcc_overvoltage = 1;
      cyc(4);
      ex(6, 8'h01);
      vcc_overvoltage = 0;
      cyc(RECC + 20);
      ex(6, 8'h00);
      $display("timers done");
      slow = 1;
      for (int i = 0; i < 5; i++) begin
         wait_gate(1);
         halt[i] = 1;
         cyc(4);
         ex(0, 8'h00);
         if (i > 1) ex(1, 8'h01);
         halt = '0;
         cyc(10);
      end
      slow = 0;
      thermal_shutdown_input = 1;
      cyc(540);
      ex(3, REF_FLOOR);
      supply_above_start = 0;
      cyc(6);
      supply_above_start = 1;
      cyc(6);
      ex(3, REF_FLOOR);
      dim_level = 8'($random(seed));
      dim_input = 0;
      cyc(5);
      ex(3, 8'((16'(REF_FLOOR) * dim_level) >> 8));
      $display("reference done");
      light_load = 1;
      cyc(5);
      ex(4, 8'(VALLEY_LOW_LINE + VALLEY_LIGHT_EXTRA));
      line_high = 1;
      light_load = 0;
      cyc(5);
      ex(4, 8'(VALLEY_HIGH_LINE));
      comp_code = 8'($random(seed));
      line_zero = 1;
      cyc(5);
      ex(8, comp_code);
      cyc(2);
      do_reset(1);
      supply_above_start = 1;
      cyc(10);
      shutdown_pin_fault = 1;
      cyc(4);
      shutdown_pin_fault = 0;
      cyc(RECC + 50);
      ex(7, 8'h01);
      ex(0, 8'h00);
      cyc(2);
      $display("latch done");
      print_verdict();
   end
   initial begin
      #2_000_000;
      n_mismatch++;
      $display("[ERR] %0t watchdog", $time);
      print_verdict();
   end
endmodule : lfs_fault_seq_tb
